/* File: rtl/tvo_output_diag.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - each channel takes its table only from its own main processor link
// - a point conducts only when two of three channel drivers command it
// - the output vote check runs periodically and covers every point
// - invert one point at a time on one driver, stepping in sequence
// - read the inverted point back via loop-back and compare to expectation
// - stuck-on or stuck-off points alarmed in under half a second
// - stuck voter switches and their drive faults are alarmed
// - each inversion lasts under 2 ms, about 500 us typical
// - the check can be switched off so loads see no inversions
// - loop-back samples all sixteen points in under 1 ms per scan
// - alarms for field power loss and points shorted on or off
module tvo_output_diag (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire tvo_pkg::tvo_table_t   table_a,
  input  wire logic                  table_a_valid,
  input  wire tvo_pkg::tvo_table_t   table_b,
  input  wire logic                  table_b_valid,
  input  wire tvo_pkg::tvo_table_t   table_c,
  input  wire logic                  table_c_valid,
  input  wire logic                  check_enable,
  input  wire logic                  field_power_ok,
  input  wire tvo_pkg::tvo_table_t   loopback,
  output tvo_pkg::tvo_table_t        drive_a,
  output tvo_pkg::tvo_table_t        drive_b,
  output tvo_pkg::tvo_table_t        drive_c,
  output tvo_pkg::tvo_table_t        point_out,
  output tvo_pkg::tvo_table_t        readback,
  output tvo_pkg::tvo_alarm_t        alarms,
  output logic                       check_busy
);

  logic rst_s1;
  logic rst_sync_b;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1     <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_s1     <= 1'b1;
      rst_sync_b <= rst_s1;
    end
  end

  // per-channel command tables, each written only from its own link
  tvo_pkg::tvo_table_t cmd_a;
  tvo_pkg::tvo_table_t cmd_b;
  tvo_pkg::tvo_table_t cmd_c;
  tvo_pkg::tvo_table_t next_cmd_a;
  tvo_pkg::tvo_table_t next_cmd_b;
  tvo_pkg::tvo_table_t next_cmd_c;

  always_comb begin
    next_cmd_a = table_a_valid ? table_a : cmd_a;
    next_cmd_b = table_b_valid ? table_b : cmd_b;
    next_cmd_c = table_c_valid ? table_c : cmd_c;
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cmd_a <= '0;
      cmd_b <= '0;
      cmd_c <= '0;
    end else begin
      cmd_a <= next_cmd_a;
      cmd_b <= next_cmd_b;
      cmd_c <= next_cmd_c;
    end
  end

  // diagnostic sequencer
  tvo_pkg::tvo_state_t    state;
  tvo_pkg::tvo_state_t    next_state;
  logic [3:0]             pt;
  logic [3:0]             next_pt;
  logic [1:0]             ch;
  logic [1:0]             next_ch;
  logic [tvo_pkg::CNT_W-1:0] cnt;
  logic [tvo_pkg::CNT_W-1:0] next_cnt;
  tvo_pkg::tvo_table_t    sw_on_fail;
  tvo_pkg::tvo_table_t    next_sw_on_fail;
  tvo_pkg::tvo_table_t    sw_off_fail;
  tvo_pkg::tvo_table_t    next_sw_off_fail;
  logic [2:0]             ch_fault;
  logic [2:0]             next_ch_fault;

  localparam logic [tvo_pkg::CNT_W-1:0] GAP_N =
    tvo_pkg::CNT_W'(tvo_pkg::STEP_GAP_CYC - 1);
  localparam logic [tvo_pkg::CNT_W-1:0] SETTLE_N =
    tvo_pkg::CNT_W'(tvo_pkg::SETTLE_CYC - 1);

  tvo_pkg::tvo_table_t drv [3];
  tvo_pkg::tvo_table_t inv_mask;

  always_comb begin
    inv_mask = '0;
    if (state == tvo_pkg::TVO_INVERT || state == tvo_pkg::TVO_SAMPLE) begin
      inv_mask[pt] = 1'b1;
    end
  end

  always_comb begin
    next_state       = state;
    next_pt          = pt;
    next_ch          = ch;
    next_cnt         = cnt;
    next_sw_on_fail  = sw_on_fail;
    next_sw_off_fail = sw_off_fail;
    next_ch_fault    = ch_fault;
    unique case (state)
      tvo_pkg::TVO_IDLE: begin
        if (check_enable) begin
          next_state = tvo_pkg::TVO_GAP;
          next_cnt   = '0;
        end
      end
      tvo_pkg::TVO_GAP: begin
        if (!check_enable) begin
          next_state = tvo_pkg::TVO_IDLE;
        end else if (cnt == GAP_N) begin
          next_state = tvo_pkg::TVO_INVERT;
          next_cnt   = '0;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      tvo_pkg::TVO_INVERT: begin
        if (cnt == SETTLE_N) begin
          next_state = tvo_pkg::TVO_SAMPLE;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      tvo_pkg::TVO_SAMPLE: begin
        // one driver flipped: a healthy voter flips the point only when
        // the other two disagree; otherwise output must hold the voted value
        if (loopback[pt] != point_expect(pt)) begin
          next_ch_fault[ch] = 1'b1;
          // the level actually seen tells which way the point is stuck
          if (loopback[pt]) begin
            next_sw_on_fail[pt] = 1'b1;
          end else begin
            next_sw_off_fail[pt] = 1'b1;
          end
        end else begin
          next_ch_fault[ch] = 1'b0;
          next_sw_on_fail[pt]  = 1'b0;
          next_sw_off_fail[pt] = 1'b0;
        end
        next_state = tvo_pkg::TVO_RESTORE;
      end
      tvo_pkg::TVO_RESTORE: begin
        next_cnt   = '0;
        next_state = tvo_pkg::TVO_GAP;
        if (ch == 2'd2) begin
          next_ch = 2'd0;
          next_pt = pt + 1'b1;
        end else begin
          next_ch = ch + 1'b1;
        end
      end
      default: next_state = tvo_pkg::TVO_IDLE;
    endcase
  end

  function automatic logic point_expect(input logic [3:0] p);
    logic [2:0] d;
    d = {drv[2][p], drv[1][p], drv[0][p]};
    point_expect = (d[0] & d[1]) | (d[1] & d[2]) | (d[0] & d[2]);
  endfunction

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state       <= tvo_pkg::TVO_IDLE;
      pt          <= '0;
      ch          <= '0;
      cnt         <= '0;
      sw_on_fail  <= '0;
      sw_off_fail <= '0;
      ch_fault    <= '0;
    end else begin
      state       <= next_state;
      pt          <= next_pt;
      ch          <= next_ch;
      cnt         <= next_cnt;
      sw_on_fail  <= next_sw_on_fail;
      sw_off_fail <= next_sw_off_fail;
      ch_fault    <= next_ch_fault;
    end
  end

  // drivers: only the channel under test sees the inversion
  always_comb begin
    drv[0] = cmd_a ^ ((ch == 2'd0) ? inv_mask : '0);
    drv[1] = cmd_b ^ ((ch == 2'd1) ? inv_mask : '0);
    drv[2] = cmd_c ^ ((ch == 2'd2) ? inv_mask : '0);
  end

  tvo_pkg::tvo_table_t vote_w;
  genvar g;
  generate
    for (g = 0; g < tvo_pkg::NUM_POINTS; g++) begin : g_vote
      tvo_voter u_voter (
        .drive   ({drv[2][g], drv[1][g], drv[0][g]}),
        .conduct (vote_w[g])
      );
    end
  endgenerate

  // loop-back capture every cycle, all 16 points in parallel
  tvo_pkg::tvo_table_t next_readback;
  tvo_pkg::tvo_alarm_t next_alarms;
  always_comb begin
    next_readback                = loopback;
    // compare against the registered point level so a table change or a
    // restore cycle does not raise a one-cycle false alarm
    next_alarms.stuck_on         = sw_on_fail | (~point_out & loopback & {16{field_power_ok}});
    next_alarms.stuck_off        = sw_off_fail | (point_out & ~loopback & {16{field_power_ok}});
    next_alarms.switch_fault     = ch_fault;
    next_alarms.field_power_loss = ~field_power_ok;
    if (state == tvo_pkg::TVO_INVERT || state == tvo_pkg::TVO_SAMPLE) begin
      // the point under test is judged by the sampler, not the static compare
      next_alarms.stuck_on[pt]  = sw_on_fail[pt];
      next_alarms.stuck_off[pt] = sw_off_fail[pt];
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      drive_a   <= '0;
      drive_b   <= '0;
      drive_c   <= '0;
      point_out <= '0;
      readback  <= '0;
      alarms    <= '0;
    end else begin
      drive_a   <= drv[0];
      drive_b   <= drv[1];
      drive_c   <= drv[2];
      point_out <= vote_w;
      readback  <= next_readback;
      alarms    <= next_alarms;
    end
  end

  assign check_busy = (state == tvo_pkg::TVO_INVERT) || (state == tvo_pkg::TVO_SAMPLE);

endmodule

/* File: common/tvo_pkg.sv */
package tvo_pkg;

  localparam int NUM_POINTS = 16;
  localparam int NUM_CHAN   = 3;

  // clock rate
  localparam int CLK_HZ = 10_000_000;

  // timing figures as printed, in their own units
  localparam int GLITCH_TYP_US     = 500;
  localparam int GLITCH_MAX_US     = 2000;
  localparam int DETECT_MAX_MS     = 500;
  localparam int SCAN_MAX_US       = 1000;

  // cycle counts derived from the figures
  localparam int GLITCH_CYC     = GLITCH_TYP_US * (CLK_HZ / 1_000_000);
  localparam int GLITCH_MAX_CYC = GLITCH_MAX_US * (CLK_HZ / 1_000_000);
  // one scan slot per point, 16 slots fit inside half the scan limit
  localparam int SCAN_SLOT_CYC  = (SCAN_MAX_US * (CLK_HZ / 1_000_000)) / (2 * NUM_POINTS);
  // settle time before sampling the inverted point
  localparam int SETTLE_CYC     = GLITCH_CYC - 100;
  // gap between test steps; 48 steps must finish inside the detect limit
  localparam int STEP_GAP_CYC   = 20_000;
  localparam int DETECT_MAX_CYC = DETECT_MAX_MS * (CLK_HZ / 1000);

  localparam int CNT_W = 24;

  typedef logic [NUM_POINTS-1:0] tvo_table_t;

  typedef enum logic [2:0] {
    TVO_IDLE   = 3'b000,
    TVO_GAP    = 3'b001,
    TVO_INVERT = 3'b010,
    TVO_SAMPLE = 3'b011,
    TVO_RESTORE= 3'b100
  } tvo_state_t;

  typedef struct packed {
    tvo_table_t stuck_on;
    tvo_table_t stuck_off;
    logic [NUM_CHAN-1:0] switch_fault;
    logic field_power_loss;
  } tvo_alarm_t;

endpackage

/* File: rtl/tvo_voter.sv */
`timescale 1ns/1ps
module tvo_voter (
  input  wire logic [2:0] drive,
  output logic            conduct
);
  // two-of-three parallel-series switch path
  assign conduct = (drive[0] & drive[1]) | (drive[1] & drive[2]) | (drive[0] & drive[2]);
endmodule

/* File: testbench/tvo_mp_model.sv */
`timescale 1ns/1ps
module tvo_mp_model (
  input  wire logic          clk,
  output tvo_pkg::tvo_table_t table_a,
  output logic               table_a_valid,
  output tvo_pkg::tvo_table_t table_b,
  output logic               table_b_valid,
  output tvo_pkg::tvo_table_t table_c,
  output logic               table_c_valid
);
  initial begin
    {table_a, table_b, table_c} = 48'h0;
    {table_a_valid, table_b_valid, table_c_valid} = 3'h0;
  end
  // each link carries only its own processor's word, with a one-cycle strobe
  task automatic send(input logic [2:0] m, input tvo_pkg::tvo_table_t a, b, c);
    @(negedge clk);
    {table_a_valid, table_b_valid, table_c_valid} = {m[0], m[1], m[2]};
    {table_a, table_b, table_c} = {a, b, c};
    @(negedge clk);
    {table_a_valid, table_b_valid, table_c_valid} = 3'h0;
    // idle word is scrambled so a load without strobe shows up
    {table_a, table_b, table_c} = ~{table_a, table_b, table_c};
  endtask
endmodule

/* File: testbench/tvo_output_diag_checker.sv */
`timescale 1ns/1ps
module tvo_checker (
  input wire logic                clk,
  input wire logic                rst_b,
  input wire tvo_pkg::tvo_table_t table_a,
  input wire logic                table_a_valid,
  input wire logic                check_enable,
  input wire logic                field_power_ok,
  input wire tvo_pkg::tvo_table_t loopback,
  input wire tvo_pkg::tvo_table_t drive_a,
  input wire tvo_pkg::tvo_table_t drive_b,
  input wire tvo_pkg::tvo_table_t drive_c,
  input wire tvo_pkg::tvo_table_t point_out,
  input wire tvo_pkg::tvo_alarm_t alarms,
  input wire logic                check_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [15:0] busy_cnt;
  logic [15:0] off_cnt;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt <= 16'h0;
      off_cnt  <= 16'h0;
    end else begin
      busy_cnt <= check_busy ? busy_cnt + 16'h1 : 16'h0;
      off_cnt  <= check_enable ? 16'h0 : off_cnt + {15'h0, off_cnt != 16'hffff};
    end
  end
  a_load_own: assert property (!check_busy [*3] ##0 $past(table_a_valid, 2)
    |-> drive_a == $past(table_a, 2)) else $error("table a lost");
  a_vote_two: assert property (point_out ==
    ((drive_a & drive_b) | (drive_b & drive_c) | (drive_a & drive_c))) else $error("bad vote");
  a_glitch_max: assert property (busy_cnt < tvo_pkg::GLITCH_MAX_CYC)
    else $error("glitch too long");
  a_glitch_typ: assert property ($fell(check_busy) |-> busy_cnt >= tvo_pkg::SETTLE_CYC)
    else $error("glitch too short");
  a_off_quiet: assert property (off_cnt > 16'h1770 |-> !check_busy)
    else $error("check while off");
  a_power_flag: assert property (!field_power_ok [*2] |-> ##[0:2] alarms.field_power_loss)
    else $error("no power alarm");
  // a point under inversion is judged by the sampler at the end of the step
  a_stuck_on: assert property ((!check_busy && field_power_ok
    && (loopback & ~point_out) != 16'h0) [*3]
    |-> ##[0:2] alarms.stuck_on != 16'h0) else $error("no stuck on");
  a_stuck_off: assert property ((!check_busy && field_power_ok
    && (point_out & ~loopback) != 16'h0) [*3]
    |-> ##[0:2] alarms.stuck_off != 16'h0) else $error("no stuck off");
endmodule

/* File: testbench/tvo_output_diag_tb.sv */
`timescale 1ns/1ps
module tvo_output_diag_tb;
  logic                clk = 1'b0;
  logic                rst_b = 1'b0;
  logic                check_enable = 1'b0;
  logic                field_power_ok = 1'b1;
  logic                table_a_valid, table_b_valid, table_c_valid, check_busy;
  tvo_pkg::tvo_table_t table_a, table_b, table_c, loopback, readback, point_out;
  tvo_pkg::tvo_table_t drive_a, drive_b, drive_c, wa, wb, wc, ep;
  tvo_pkg::tvo_table_t ea = 16'h0;
  tvo_pkg::tvo_table_t eb = 16'h0;
  tvo_pkg::tvo_table_t ec = 16'h0;
  tvo_pkg::tvo_table_t s_on = 16'h0;
  tvo_pkg::tvo_table_t s_off = 16'h0;
  tvo_pkg::tvo_alarm_t alarms;
  logic [2:0]          m;
  int                  err_total = 0;
  int                  check_count = 0;
  int                  cyc = 0;
  int                  n;
  // send mask, words a b c, expected voted points
  logic [66:0]         rows [4] = '{{3'h7, 16'hffff, 16'h0, 16'h0, 16'h0},
    {3'h7, 16'h00ff, 16'h0f0f, 16'h3333, 16'h033f}, {3'h2, 16'h0, 16'hffff, 16'h0, 16'h33ff},
    {3'h5, 16'ha5a5, 16'h0, 16'h5a5a, 16'hffff}};
  always #50 clk = ~clk;
  // field side: points read back as driven, unless a fault is injected
  assign loopback = (point_out | s_on) & ~s_off;
  tvo_mp_model mp (.clk, .table_a, .table_a_valid, .table_b, .table_b_valid, .table_c,
    .table_c_valid);
  tvo_output_diag DUT (.clk, .rst_b, .table_a, .table_a_valid, .table_b, .table_b_valid,
    .table_c, .table_c_valid, .check_enable, .field_power_ok, .loopback, .drive_a, .drive_b,
    .drive_c, .point_out, .readback, .alarms, .check_busy);
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t %s", $time, msg);
    end
  endtask
  task automatic test_done();
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      $display("mismatch t=%0t timeout", $time);
      test_done();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    cmp(point_out, 16'h0, "reset");
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    foreach (rows[i]) begin
      {m, wa, wb, wc, ep} = rows[i];
      mp.send(m, wa, wb, wc);
      if (m[0]) ea = wa;
      if (m[1]) eb = wb;
      if (m[2]) ec = wc;
      repeat (3) @(negedge clk);
      cmp({drive_a, drive_b, drive_c}, {ea, eb, ec}, "own table");
      cmp(point_out, ep, "vote");
    end
    s_off = 16'h0200;
    repeat (4) @(negedge clk);
    cmp(alarms.stuck_off, 16'h0200, "stuck off");
    cmp(readback, 16'hfdff, "readback");
    s_off = 16'h0;
    field_power_ok = 1'b0;
    repeat (4) @(negedge clk);
    cmp(alarms.field_power_loss, 1'b1, "power");
    field_power_ok = 1'b1;
    mp.send(3'h7, 16'h0, 16'h0, 16'h0);
    s_on = 16'h0020;
    repeat (4) @(negedge clk);
    cmp(alarms.stuck_on, 16'h0020, "stuck on");
    s_on = 16'h0;
    check_enable = 1'b1;
    while (check_busy !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmp({drive_a, drive_b, drive_c, point_out}, 64'h0001_0000_0000_0000, "invert");
    n = 0;
    while (check_busy === 1'b1) begin
      @(negedge clk);
      n++;
    end
    cmp(n + 10 > tvo_pkg::SETTLE_CYC && n < tvo_pkg::GLITCH_MAX_CYC, 1'b1, "glitch");
    repeat (2) @(negedge clk);
    cmp(drive_a, 16'h0, "restore");
    while (check_busy !== 1'b1) @(negedge clk);
    // loopback follows the inverted driver as if its switch were stuck
    s_on = 16'h1;
    @(negedge clk);
    cmp({drive_a, drive_b}, {16'h0, 16'h1}, "next driver");
    while (check_busy === 1'b1) @(negedge clk);
    s_on = 16'h0;
    repeat (2) @(negedge clk);
    cmp(alarms.switch_fault, 3'h2, "switch");
    cmp(alarms.stuck_on, 16'h0001, "sampled stuck on");
    check_enable = 1'b0;
    n = 0;
    repeat (25000) begin
      @(negedge clk);
      n += check_busy;
    end
    cmp(n, 0, "disabled");
    test_done();
  end
endmodule
bind tvo_output_diag tvo_checker chk (.clk, .rst_b, .table_a, .table_a_valid, .check_enable,
  .field_power_ok, .loopback, .drive_a, .drive_b, .drive_c, .point_out, .alarms, .check_busy);
